// ==== shared/adcc_pkg.sv ====
// Package for the converter control block: register map, field layout, resets, timing
package adcc_pkg;
  // ==========================================================================
  // Register indices and byte addresses (byte address is four times the index)
  localparam logic [7:0] IDX_CONTROL = 8'h00;
  localparam logic [7:0] IDX_SETUP = 8'h04;
  localparam logic [7:0] IDX_PENDING = 8'h08;
  localparam logic [7:0] IDX_MASK = 8'h0c;
  localparam logic [7:0] IDX_RESULT = 8'h16;
  localparam logic [7:0] IDX_OFFSET = 8'h18;
  localparam logic [7:0] IDX_STATUS = 8'h20;
  localparam logic [7:0] IDX_UPPER = 8'h24;
  localparam logic [7:0] IDX_LOWER = 8'h28;
  localparam logic [9:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [9:0] ADDR_SETUP = {IDX_SETUP, 2'b00};
  localparam logic [9:0] ADDR_PENDING = {IDX_PENDING, 2'b00};
  localparam logic [9:0] ADDR_MASK = {IDX_MASK, 2'b00};
  localparam logic [9:0] ADDR_RESULT = {IDX_RESULT, 2'b00};
  localparam logic [9:0] ADDR_OFFSET = {IDX_OFFSET, 2'b00};
  localparam logic [9:0] ADDR_STATUS = {IDX_STATUS, 2'b00};
  localparam logic [9:0] ADDR_UPPER = {IDX_UPPER, 2'b00};
  localparam logic [9:0] ADDR_LOWER = {IDX_LOWER, 2'b00};
  // ==========================================================================
  // Control register bits
  localparam int CTL_POWER = 0;
  localparam int CTL_CAL_EN = 1;
  localparam int CTL_START = 2;
  localparam int CTL_SOFT_RST = 3;
  localparam int CTL_STOP = 4;
  localparam int CTL_CMP_EN = 5;
  localparam int CTL_CAL_DIS = 6;
  localparam int CTL_AUTO_OFFSET = 7;
  localparam int CTL_VOICE = 8;
  localparam int CTL_DMA = 9;
  localparam logic [9:0] CTL_WMASK = 10'h3b7;
  localparam logic [9:0] CTL_RESET = 10'h000;
  // ==========================================================================
  // Setup register fields
  localparam int CFG_CM_NULL = 0;
  localparam int CFG_CHAN_LSB = 1;
  localparam int CFG_BIAS_LSB = 4;
  localparam int CFG_OSR_LSB = 6;
  localparam int CFG_ATTEN_LSB = 8;
  localparam int CFG_CONTINUOUS_MODE = 11;
  localparam int CFG_COMB_SKIP = 18;
  localparam int CFG_MIC_RATE = 20;
  localparam int CFG_WAKE_SKIP = 21;
  localparam int CFG_MIC_OUT = 22;
  localparam logic [31:0] CFG_WMASK = 32'h0074_0bff;
  localparam logic [31:0] CFG_RESET = 32'hffff_ffff;
  // ==========================================================================
  // Flags, other resets
  localparam int FLG_CAL = 0;
  localparam int FLG_BUSY = 1;
  localparam int FLG_EOC = 2;
  localparam int FLG_WIN = 3;
  localparam logic [3:0] MASK_RESET = 4'hf;
  localparam logic [31:0] UPPER_RESET = 32'hffff_ffff;
  localparam logic [31:0] LOWER_RESET = 32'h0000_0000;
  // ==========================================================================
  // Timing at a 250 MHz core clock
  localparam int CLK_PERIOD_PS = 4000;
  localparam int CORE_KHZ = 250000;
  localparam int WAKE_NS = 5000;
  localparam int WAKE_CYC_INT = (WAKE_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam logic [10:0] WAKE_CYC = 11'(WAKE_CYC_INT);
  localparam int MIC_SLOW_KHZ = 800;
  localparam int MIC_FAST_KHZ = 1600;
  localparam logic [7:0] MIC_HALF_SLOW = 8'(CORE_KHZ / (2 * MIC_SLOW_KHZ));
  localparam logic [7:0] MIC_HALF_FAST = 8'(CORE_KHZ / (2 * MIC_FAST_KHZ));
  // ==========================================================================
  typedef enum logic [1:0] {ST_IDLE, ST_WAKE, ST_CAL, ST_ACQ} adcc_state_t;
endpackage : adcc_pkg

// ==== rtl/adcc_control.sv ====
// Converter control block: APB register bank, conversion sequencer, mic clock, DMA request
//
// Overview of operation
// - Control bit 0 powers the converter; software sets it before any conversion.
// - Control bit 1 enables calibration; a control write clears it when bit 1 is zero or calibration-disable (bit 6) is one.
// - Writing one to control bit 2 starts the conversion phase.
// - Writing one to control bit 3 returns every register to its reset value.
// - Control bit 4 halts continuous conversion and powers down the converter.
// - Control bit 5 compares each result with the window and sets its flag.
// - Control bit 7 lets calibration results update the offset register.
// - Control bit 8 enables the voice filter chain.
// - Setup bit 0, reset one, selects common-mode current nulling.
// - Setup bits 3:1 select the input channel, reset value seven.
// - Setup bits 5:4 select the single-ended bias voltage.
// - Setup bits 7:6 select the oversampling ratio.
// - Setup bits 9:8 select the input attenuator.
// - Setup bit 11 chooses single or continuous conversion.
// - Setup bit 18 bypasses the comb filter.
// - Setup bit 20 picks the mic clock rate, 0.8 or 1.6 MHz.
// - Setup bit 21 skips the wake-up wait before conversion.
// - Setup bit 22 drives the mic clock out on the general pin.
// - Mask register resets to all four events masked; pending view shows only unmasked flags.
// - Result register holds the converted value in two's complement.
// - Upper threshold resets to all ones, lower threshold to zero.
// - Each single acquisition starts with a 5 us wake-up phase unless setup bit 21 is set (its reset value is one).
// - Busy flag is set during conversion and setup writes are blocked meanwhile.
// - Calibration end raises its flag and, with control bit 7 set, writes the measured offset.
// - Reading pending view clears flags; busy clears only once no longer busy.
`timescale 1ns/1ps
`default_nettype none
module adcc_control #(
  parameter int ADDR_W = 12,
  parameter int DATA_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Analog converter core
  output logic anaPowerOn,
  output logic commonModeNullEnable,
  output logic [2:0] inputChannelSelect,
  output logic [1:0] biasVoltageSelect,
  output logic [1:0] oversamplingRatio,
  output logic [1:0] attenuatorSelect,
  output logic combBypass,
  output logic voiceFilterEnable,
  output logic calPhase,
  output logic sampleStart,
  input wire logic sampleDone,
  input wire logic [DATA_W-1:0] sampleData,
  // Microphone clock on the first general pin
  output logic micClkOut,
  output logic micClkOe,
  // DMA request handshake
  output logic dmaReq,
  input wire logic dmaAck
);
  // ==========================================================================
  // Bus decode
  logic [9:0] ctrl_q;
  logic [31:0] adc_setup_q;
  logic [3:0] mask_q;
  logic [31:0] result_q;
  logic [31:0] offset_q;
  logic [31:0] upper_q;
  logic [31:0] lower_q;
  logic [3:0] srFlags_q;
  logic [3:0] pend_q;
  logic swRst_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  adcc_pkg::adcc_state_t state_q;
  logic [10:0] wakeCnt_q;
  logic clr;
  logic accessDone;
  logic wrEn;
  logic rdDone;
  logic hit;
  logic [31:0] rdMux;
  logic busy;
  logic calEvt;
  logic acqEvt;
  logic [31:0] sampleExt;
  logic [31:0] corrected;
  logic inWin;
  logic [3:0] evt;
  logic wrCtrl;
  logic wrConf;
  logic wrStatus;
  logic rdPending;
  logic runOk;
  logic [7:0] micCnt_q;
  logic [7:0] micHalf;
  adcc_pkg::adcc_state_t lastState_q;
  logic lastDone_q;

  assign clr = reset | swRst_q;
  assign accessDone = psel & penable & pready_q;
  assign wrEn = accessDone & pwrite & hit;
  assign rdDone = accessDone & ~pwrite & hit;
  assign wrCtrl = wrEn && paddr[9:0] == adcc_pkg::ADDR_CONTROL;
  assign wrConf = wrEn && paddr[9:0] == adcc_pkg::ADDR_SETUP;
  assign wrStatus = wrEn && paddr[9:0] == adcc_pkg::ADDR_STATUS;
  assign rdPending = rdDone && paddr[9:0] == adcc_pkg::ADDR_PENDING;
  assign busy = state_q != adcc_pkg::ST_IDLE;

  always_comb begin
    hit = paddr[ADDR_W-1:10] == '0;
    rdMux = 32'h0000_0000;
    unique case (paddr[9:0])
      adcc_pkg::ADDR_CONTROL: rdMux = {22'h00_0000, ctrl_q};
      adcc_pkg::ADDR_SETUP: rdMux = adc_setup_q;
      adcc_pkg::ADDR_PENDING: rdMux = {28'h000_0000, pend_q & ~mask_q};
      adcc_pkg::ADDR_MASK: rdMux = {28'h000_0000, mask_q};
      adcc_pkg::ADDR_RESULT: rdMux = result_q;
      adcc_pkg::ADDR_OFFSET: rdMux = offset_q;
      adcc_pkg::ADDR_STATUS: rdMux = {28'h000_0000, srFlags_q};
      adcc_pkg::ADDR_UPPER: rdMux = upper_q;
      adcc_pkg::ADDR_LOWER: rdMux = lower_q;
      default: hit = 1'b0;
    endcase
  end

  // ==========================================================================
  // APB answer: one wait state, data and error captured on the same edge that raises pready
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel & penable & ~pready_q;
      if (psel & penable & ~pready_q) begin
        prdata_q <= (hit && !pwrite) ? rdMux : 32'h0000_0000;
        pslverr_q <= ~hit;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;

  // ==========================================================================
  // Soft reset pulse; takes effect at the edge after the write completes
  always_ff @(posedge core_clk) begin
    if (reset) begin
      swRst_q <= 1'b0;
    end else begin
      swRst_q <= wrCtrl & pwdata[adcc_pkg::CTL_SOFT_RST];
    end
  end

  // ==========================================================================
  // Control register
  always_ff @(posedge core_clk) begin
    if (clr) begin
      ctrl_q <= adcc_pkg::CTL_RESET;
    end else if (wrCtrl) begin
      ctrl_q <= pwdata[9:0] & adcc_pkg::CTL_WMASK;
      // Calibration stays on until software asks for it to go off
      ctrl_q[adcc_pkg::CTL_CAL_EN] <= pwdata[adcc_pkg::CTL_CAL_EN]
          & ~pwdata[adcc_pkg::CTL_CAL_DIS];
    end else if (acqEvt && !(adc_setup_q[adcc_pkg::CFG_CONTINUOUS_MODE] && runOk)) begin
      ctrl_q[adcc_pkg::CTL_START] <= 1'b0;
    end
  end

  // ==========================================================================
  // Setup register, locked while a conversion runs
  always_ff @(posedge core_clk) begin
    if (clr) begin
      adc_setup_q <= adcc_pkg::CFG_RESET;
    end else if (wrConf && !busy) begin
      adc_setup_q <= (pwdata & adcc_pkg::CFG_WMASK) | ~adcc_pkg::CFG_WMASK;
    end
  end

  // ==========================================================================
  // Mask and window limits
  always_ff @(posedge core_clk) begin
    if (clr) begin
      mask_q <= adcc_pkg::MASK_RESET;
      upper_q <= adcc_pkg::UPPER_RESET;
      lower_q <= adcc_pkg::LOWER_RESET;
    end else if (wrEn) begin
      if (paddr[9:0] == adcc_pkg::ADDR_MASK) begin
        mask_q <= pwdata[3:0];
      end
      if (paddr[9:0] == adcc_pkg::ADDR_UPPER) begin
        upper_q <= pwdata;
      end
      if (paddr[9:0] == adcc_pkg::ADDR_LOWER) begin
        lower_q <= pwdata;
      end
    end
  end

  // ==========================================================================
  // Sequencer
  assign runOk = ctrl_q[adcc_pkg::CTL_POWER] & ~ctrl_q[adcc_pkg::CTL_STOP];
  assign calEvt = state_q == adcc_pkg::ST_CAL && sampleDone;
  assign acqEvt = state_q == adcc_pkg::ST_ACQ && sampleDone;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      state_q <= adcc_pkg::ST_IDLE;
      wakeCnt_q <= 11'h000;
    end else if (!runOk) begin
      // Power off or stop aborts whatever is in flight
      state_q <= adcc_pkg::ST_IDLE;
      wakeCnt_q <= 11'h000;
    end else begin
      unique case (state_q)
        adcc_pkg::ST_IDLE: begin
          wakeCnt_q <= 11'h000;
          if (ctrl_q[adcc_pkg::CTL_START]) begin
            if (!adc_setup_q[adcc_pkg::CFG_WAKE_SKIP]) begin
              state_q <= adcc_pkg::ST_WAKE;
            end else if (ctrl_q[adcc_pkg::CTL_CAL_EN]) begin
              state_q <= adcc_pkg::ST_CAL;
            end else begin
              state_q <= adcc_pkg::ST_ACQ;
            end
          end
        end
        adcc_pkg::ST_WAKE: begin
          wakeCnt_q <= wakeCnt_q + 11'h001;
          if (wakeCnt_q == adcc_pkg::WAKE_CYC - 11'h001) begin
            state_q <= ctrl_q[adcc_pkg::CTL_CAL_EN] ? adcc_pkg::ST_CAL : adcc_pkg::ST_ACQ;
          end
        end
        adcc_pkg::ST_CAL: begin
          if (sampleDone) begin
            state_q <= adcc_pkg::ST_ACQ;
          end
        end
        adcc_pkg::ST_ACQ: begin
          // Continuous mode loops without a new wake-up phase
          if (sampleDone && !(adc_setup_q[adcc_pkg::CFG_CONTINUOUS_MODE] && ctrl_q[adcc_pkg::CTL_START])) begin
            state_q <= adcc_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================================================
  // Result path: offset removal and window compare
  assign sampleExt = 32'(signed'(sampleData));
  assign corrected = ctrl_q[adcc_pkg::CTL_CAL_EN] ? sampleExt - offset_q : sampleExt;
  assign inWin = $signed(corrected) <= $signed(upper_q)
      && $signed(corrected) >= $signed(lower_q);

  always_ff @(posedge core_clk) begin
    if (clr) begin
      result_q <= 32'h0000_0000;
    end else if (acqEvt) begin
      result_q <= corrected;
    end
  end

  // Hardware update wins over a software write in the same cycle
  always_ff @(posedge core_clk) begin
    if (clr) begin
      offset_q <= 32'h0000_0000;
    end else if (calEvt && ctrl_q[adcc_pkg::CTL_AUTO_OFFSET]) begin
      offset_q <= sampleExt;
    end else if (wrEn && paddr[9:0] == adcc_pkg::ADDR_OFFSET) begin
      offset_q <= pwdata;
    end
  end

  // ==========================================================================
  // Flags: event sets always win over clears
  assign evt[adcc_pkg::FLG_CAL] = calEvt;
  assign evt[adcc_pkg::FLG_BUSY] = busy;
  assign evt[adcc_pkg::FLG_EOC] = acqEvt;
  assign evt[adcc_pkg::FLG_WIN] = acqEvt & ctrl_q[adcc_pkg::CTL_CMP_EN] & inWin;

  generate
    for (genvar i = 0; i < 4; i++) begin : g_flag
      always_ff @(posedge core_clk) begin
        if (clr) begin
          pend_q[i] <= 1'b0;
          srFlags_q[i] <= 1'b0;
        end else begin
          pend_q[i] <= evt[i] | (pend_q[i] & ~rdPending);
          if (i == adcc_pkg::FLG_BUSY) begin
            srFlags_q[i] <= evt[i];
          end else begin
            srFlags_q[i] <= evt[i] | (srFlags_q[i] & ~(wrStatus & pwdata[i]));
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // Analog controls, all registered
  always_ff @(posedge core_clk) begin
    if (clr) begin
      anaPowerOn <= 1'b0;
      commonModeNullEnable <= 1'b1;
      inputChannelSelect <= 3'h7;
      biasVoltageSelect <= 2'h3;
      oversamplingRatio <= 2'h3;
      attenuatorSelect <= 2'h3;
      combBypass <= 1'b1;
      voiceFilterEnable <= 1'b0;
      calPhase <= 1'b0;
      sampleStart <= 1'b0;
      lastState_q <= adcc_pkg::ST_IDLE;
      lastDone_q <= 1'b0;
    end else begin
      anaPowerOn <= runOk;
      commonModeNullEnable <= adc_setup_q[adcc_pkg::CFG_CM_NULL];
      inputChannelSelect <= adc_setup_q[adcc_pkg::CFG_CHAN_LSB +: 3];
      biasVoltageSelect <= adc_setup_q[adcc_pkg::CFG_BIAS_LSB +: 2];
      oversamplingRatio <= adc_setup_q[adcc_pkg::CFG_OSR_LSB +: 2];
      attenuatorSelect <= adc_setup_q[adcc_pkg::CFG_ATTEN_LSB +: 2];
      combBypass <= adc_setup_q[adcc_pkg::CFG_COMB_SKIP];
      voiceFilterEnable <= ctrl_q[adcc_pkg::CTL_VOICE];
      calPhase <= state_q == adcc_pkg::ST_CAL;
      // One launch on entering a phase, one after each sample the phase keeps;
      // relaunching on the last sample would start a conversion nobody collects
      sampleStart <= runOk && (state_q == adcc_pkg::ST_CAL || state_q == adcc_pkg::ST_ACQ)
          && (state_q != lastState_q || lastDone_q);
      lastState_q <= state_q;
      lastDone_q <= sampleDone;
    end
  end

  // ==========================================================================
  // Microphone clock divider; rate rounds slightly fast to whole cycles
  assign micHalf = adc_setup_q[adcc_pkg::CFG_MIC_RATE] ? adcc_pkg::MIC_HALF_FAST
      : adcc_pkg::MIC_HALF_SLOW;

  always_ff @(posedge core_clk) begin
    if (clr) begin
      micCnt_q <= 8'h00;
      micClkOut <= 1'b0;
      micClkOe <= 1'b0;
    end else begin
      micClkOe <= adc_setup_q[adcc_pkg::CFG_MIC_OUT];
      if (!adc_setup_q[adcc_pkg::CFG_MIC_OUT]) begin
        micCnt_q <= 8'h00;
        micClkOut <= 1'b0;
      end else if (micCnt_q >= micHalf - 8'h01) begin
        micCnt_q <= 8'h00;
        micClkOut <= ~micClkOut;
      end else begin
        micCnt_q <= micCnt_q + 8'h01;
      end
    end
  end

  // ==========================================================================
  // DMA request: held until acknowledged
  always_ff @(posedge core_clk) begin
    if (clr) begin
      dmaReq <= 1'b0;
    end else if (acqEvt && ctrl_q[adcc_pkg::CTL_DMA]) begin
      dmaReq <= 1'b1;
    end else if (dmaAck) begin
      dmaReq <= 1'b0;
    end
  end

  // ==========================================================================
  // Checks
  AST_WAKE_LEN: assert property (@(posedge core_clk) disable iff (clr)
      (state_q == adcc_pkg::ST_WAKE) ##1 (state_q != adcc_pkg::ST_WAKE && runOk)
      |-> $past(wakeCnt_q) == adcc_pkg::WAKE_CYC - 11'h001)
    else $error("wake-up phase length wrong");
  AST_ADC_SETUP_LOCK: assert property (@(posedge core_clk) disable iff (clr)
      (wrConf && busy) |=> adc_setup_q == $past(adc_setup_q))
    else $error("setup changed during conversion");
  AST_CAL_OFF: assert property (@(posedge core_clk) disable iff (clr)
      (wrCtrl && pwdata[adcc_pkg::CTL_CAL_DIS]) |=> !ctrl_q[adcc_pkg::CTL_CAL_EN])
    else $error("calibration not disabled");
  AST_SOFT_RESET: assert property (@(posedge core_clk) disable iff (reset)
      swRst_q |=> (mask_q == adcc_pkg::MASK_RESET && adc_setup_q == adcc_pkg::CFG_RESET
      && upper_q == adcc_pkg::UPPER_RESET && ctrl_q == adcc_pkg::CTL_RESET))
    else $error("soft reset incomplete");
  AST_STOP_POWER: assert property (@(posedge core_clk) disable iff (clr)
      ctrl_q[adcc_pkg::CTL_STOP] |=> (!anaPowerOn && state_q == adcc_pkg::ST_IDLE))
    else $error("stop did not power down");
  AST_WINDOW: assert property (@(posedge core_clk) disable iff (clr)
      (acqEvt && ctrl_q[adcc_pkg::CTL_CMP_EN] && inWin)
      |=> (srFlags_q[adcc_pkg::FLG_WIN] && pend_q[adcc_pkg::FLG_WIN]))
    else $error("window flag missing");
  AST_OFFSET_HOLD: assert property (@(posedge core_clk) disable iff (clr)
      (calEvt && !ctrl_q[adcc_pkg::CTL_AUTO_OFFSET]
      && !(wrEn && paddr[9:0] == adcc_pkg::ADDR_OFFSET)) |=> $stable(offset_q))
    else $error("offset changed without update enable");
  AST_DMA_GATE: assert property (@(posedge core_clk) disable iff (clr)
      $rose(dmaReq) |-> $past(ctrl_q[adcc_pkg::CTL_DMA]) && $past(acqEvt))
    else $error("dma request without enable");
  AST_READ_CLEAR: assert property (@(posedge core_clk) disable iff (clr)
      (rdPending && !acqEvt) |=> !pend_q[adcc_pkg::FLG_EOC])
    else $error("end flag survived read");
  AST_MIC_OFF: assert property (@(posedge core_clk) disable iff (clr)
      !adc_setup_q[adcc_pkg::CFG_MIC_OUT] |=> (!micClkOe && !micClkOut))
    else $error("mic clock driven while off");
  AST_POWER_IDLE: assert property (@(posedge core_clk) disable iff (clr)
      !ctrl_q[adcc_pkg::CTL_POWER] |=> state_q == adcc_pkg::ST_IDLE)
    else $error("conversion ran unpowered");
endmodule : adcc_control
`default_nettype wire

// ==== tb/adcc_analog_model.sv ====
// Behavioural analog converter core answering each sample request after a delay
`timescale 1ns/1ps
`default_nettype none
module adcc_analog_model #(
  parameter int DELAY = 40
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Requests from the control block
  input wire logic sampleStart,
  input wire logic calPhase,
  // Values the bench wants returned
  input wire logic [15:0] calValue,
  input wire logic [15:0] acqValue,
  // Answer
  output logic sampleDone,
  output logic [15:0] sampleData
);
  int cnt;
  // ==========================================================================
  // Sample sequencing
  always_ff @(posedge core_clk) begin
    sampleDone <= 1'b0;
    if (reset) begin
      cnt <= 0;
      sampleData <= 16'h5a5a;
    end else if (sampleStart) begin
      cnt <= DELAY;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else if (cnt == 1) begin
      cnt <= 0;
      sampleDone <= 1'b1;
      sampleData <= calPhase ? calValue : acqValue;
    end else begin
      // Data is only valid with the done pulse, so it wanders otherwise
      sampleData <= ~sampleData;
    end
  end
endmodule : adcc_analog_model
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic core_clk = 1'b0, reset = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rdat;
  logic pready, pslverr, rerr, sampleStart, sampleDone, calPhase, dmaReq;
  logic dmaAck = 1'b0, sawReq = 1'b0, anaPowerOn, cmNull, comb, micClk, micOe, voice;
  logic [2:0] chan;
  logic [1:0] bias, oversampling_ratio, att;
  logic [15:0] sampleData, calValue = 16'h0010, acqValue = 16'hff80;
  int n_fail = 0, cmp_count = 0;
  localparam logic [31:0] S1 = 32'h0050_0167;
  adcc_control DUT (.core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .anaPowerOn(anaPowerOn), .commonModeNullEnable(cmNull),
    .inputChannelSelect(chan), .biasVoltageSelect(bias), .oversamplingRatio(oversampling_ratio),
    .attenuatorSelect(att), .combBypass(comb), .voiceFilterEnable(voice), .calPhase(calPhase),
    .sampleStart(sampleStart), .sampleDone(sampleDone), .sampleData(sampleData),
    .micClkOut(micClk), .micClkOe(micOe), .dmaReq(dmaReq), .dmaAck(dmaAck));
  adcc_analog_model #(.DELAY(40)) ana (.core_clk(core_clk), .reset(reset),
    .sampleStart(sampleStart), .calPhase(calPhase), .calValue(calValue),
    .acqValue(acqValue), .sampleDone(sampleDone), .sampleData(sampleData));
  always #2 core_clk = ~core_clk;
  // Prompt DMA partner; remembers that a request was seen
  always @(posedge core_clk) begin
    dmaAck <= dmaReq & ~reset;
    if (dmaReq === 1'b1) sawReq <= 1'b1;
  end
  // ==========================================================================
  // Bus and compare helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the answer
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [9:0] a, input logic [31:0] d);
    apb(1'b1, {2'b00, a}, d);
  endtask : wr
  task automatic rd(input logic [9:0] a, input logic [31:0] e);
    apb(1'b0, {2'b00, a}, 32'h0);
    chk(rdat, e);
  endtask : rd
  task automatic wait_done();
    int k;
    k = 0;
    while (sampleDone !== 1'b1 && k < 400) begin @(posedge core_clk); k++; end
    chk(32'(k < 400), 32'h1);
    repeat (3) @(posedge core_clk);
  endtask : wait_done
  // ==========================================================================
  // Scenarios
  task automatic reset_values();
    rd(adcc_pkg::ADDR_CONTROL, 32'h0);
    rd(adcc_pkg::ADDR_SETUP, 32'hffff_ffff);
    rd(adcc_pkg::ADDR_MASK, 32'h0000_000f);
    rd(adcc_pkg::ADDR_UPPER, 32'hffff_ffff);
    rd(adcc_pkg::ADDR_LOWER, 32'h0);
    rd(adcc_pkg::ADDR_OFFSET, 32'h0);
  endtask : reset_values
  task automatic single_window();
    int k;
    wr(adcc_pkg::ADDR_MASK, 32'h0);
    wr(adcc_pkg::ADDR_UPPER, 32'h0000_0100);
    wr(adcc_pkg::ADDR_LOWER, 32'hffff_ff00);
    wr(adcc_pkg::ADDR_SETUP, S1);
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0225);
    k = 0;
    while (sampleStart !== 1'b1 && k < 2000) begin @(posedge core_clk); k++; end
    chk(32'(k >= 1248 && k <= 1256), 32'h1);
    wr(adcc_pkg::ADDR_SETUP, 32'h0);
    rd(adcc_pkg::ADDR_SETUP, S1 | ~adcc_pkg::CFG_WMASK);
    rd(adcc_pkg::ADDR_STATUS, 32'h2);
    chk({cmNull, chan, bias, oversampling_ratio, att, comb, micOe}, {S1[0], S1[3:1], S1[5:4], S1[7:6],
      S1[9:8], S1[18], S1[22]});
    wait_done();
    rd(adcc_pkg::ADDR_RESULT, 32'hffff_ff80);
    rd(adcc_pkg::ADDR_STATUS, 32'hc);
    rd(adcc_pkg::ADDR_PENDING, 32'he);
    rd(adcc_pkg::ADDR_PENDING, 32'h0);
    rd(adcc_pkg::ADDR_CONTROL, 32'h0000_0221);
    chk(32'(sawReq), 32'h1);
  endtask : single_window
  task automatic calibrated();
    wr(adcc_pkg::ADDR_STATUS, 32'hd);
    sawReq <= 1'b0;
    acqValue <= 16'h0050;
    wr(adcc_pkg::ADDR_SETUP, S1 | 32'h0020_0000);
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0087);
    wait_done();
    wait_done();
    rd(adcc_pkg::ADDR_OFFSET, 32'h10);
    rd(adcc_pkg::ADDR_RESULT, 32'h40);
    rd(adcc_pkg::ADDR_STATUS, 32'h5);
    rd(adcc_pkg::ADDR_CONTROL, 32'h0000_0083);
    chk(32'(sawReq), 32'h0);
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0143);
    rd(adcc_pkg::ADDR_CONTROL, 32'h101);
    chk(32'(voice), 32'h1);
    chk(32'(anaPowerOn), 32'h1);
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0011);
    repeat (2) @(posedge core_clk);
    chk({30'h0, anaPowerOn, voice}, 32'h0);
  endtask : calibrated
  task automatic mic_and_continuous();
    time t0;
    @(posedge micClk);
    t0 = $time;
    @(negedge micClk);
    chk(32'(($time - t0) / 64'h4), 32'(adcc_pkg::MIC_HALF_FAST));
    wr(adcc_pkg::ADDR_SETUP, S1 & ~32'h0010_0000);
    @(posedge micClk);
    t0 = $time;
    @(negedge micClk);
    chk(32'(($time - t0) / 64'h4), 32'(adcc_pkg::MIC_HALF_SLOW));
    wr(adcc_pkg::ADDR_SETUP, 32'h0020_0800);
    repeat (2) @(posedge core_clk);
    chk({30'h0, micOe, micClk}, 32'h0);
    // A calibration value that differs from the stored offset exposes a wrong update
    calValue <= 16'h0020;
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0007);
    wait_done();
    wait_done();
    rd(adcc_pkg::ADDR_PENDING, 32'h7);
    rd(adcc_pkg::ADDR_PENDING, 32'h2);
    rd(adcc_pkg::ADDR_CONTROL, 32'h0000_0007);
    rd(adcc_pkg::ADDR_OFFSET, 32'h10);
    wr(adcc_pkg::ADDR_CONTROL, 32'h0000_0040);
    rd(adcc_pkg::ADDR_STATUS, 32'h5);
  endtask : mic_and_continuous
  task automatic bad_and_soft_reset();
    apb(1'b0, 12'h004, 32'h0);
    chk({31'h0, rerr}, 32'h1);
    wr(adcc_pkg::ADDR_CONTROL, 32'h8);
    repeat (2) @(posedge core_clk);
    reset_values();
  endtask : bad_and_soft_reset
  // ==========================================================================
  // Run control
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  initial begin
    repeat (8) @(posedge core_clk);
    reset <= 1'b0;
    reset_values();
    single_window();
    calibrated();
    mic_and_continuous();
    bad_and_soft_reset();
    stop_test();
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    n_fail++;
    stop_test();
  end
endmodule : tb
`default_nettype wire
